// [dv/tb_second_channel_arb_capability.sv]
// Self-checking bench for the second channel arbitration capability register
`timescale 1ns/10ps
`default_nettype none
module tb_second_channel_arb_capability;
  logic clock;
  logic rst_n;
  logic clk_en;
  cap_pkg::cfg_req_t req;
  cap_pkg::channel_settings_t settings;
  cap_pkg::cfg_rsp_t rsp;
  logic [31:0] last;
  int fail_count;
  int checked;

  second_channel_arb_capability dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .cfg_req(req), .channel_settings(settings), .cfg_rsp(rsp));

  always #4 clock = ~clock;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  // Request at a falling edge, answer one cycle later, then one idle cycle
  task automatic access(input logic r, input logic w, input logic [11:0] a, input logic [31:0] wd,
                        input logic h, input logic [31:0] exp);
    req.rd = r;
    req.wr = w;
    req.addr = a;
    req.wdata = wd;
    req.byte_en = 4'hF;
    @(negedge clock);
    last = rsp.rdata;
    check({31'h0, rsp.ack}, 32'h1);
    check({31'h0, rsp.hit}, {31'h0, h});
    check(rsp.rdata, exp);
    req.rd = 1'b0;
    req.wr = 1'b0;
    req.wdata = 32'hA5A5A5A5;
    @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    check(rsp.rdata, 32'h0);
  endtask : access

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (1000) @(posedge clock);
    fail_count++;
    close_out();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    req = '0;
    settings = '0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    rst_n = 1'b1;
    @(negedge clock);
    access(1'b1, 1'b0, 12'h16C, 32'h0, 1'b1, 32'h077F0011);
    check({24'h0, last[31:24]}, 32'h07);
    check({25'h0, last[22:16]}, 32'h7F);
    check({31'h0, last[15]}, 32'h0);
    check({31'h0, last[14]}, 32'h0);
    check({25'h0, last[23], last[13:8]}, 32'h0);
    check({30'h0, last[4], last[0]}, 32'h3);
    check({26'h0, last[7:5], last[3:1]}, 32'h0);
    check({24'h0, last[7:0]}, 32'h11);
    for (int i = 1; i < 4; i++) begin
      access(1'b1, 1'b0, 12'h16C + 12'(i), 32'h0, 1'b1, 32'h077F0011);
    end
    $display("test field reads done");
    access(1'b0, 1'b1, 12'h16C, 32'hFFFFFFFF, 1'b1, 32'h0);
    access(1'b1, 1'b0, 12'h16C, 32'h0, 1'b1, 32'h077F0011);
    access(1'b0, 1'b1, 12'h16C, 32'h0, 1'b1, 32'h0);
    access(1'b1, 1'b1, 12'h16C, 32'h0, 1'b1, 32'h077F0011);
    $display("test writes ignored done");
    access(1'b1, 1'b0, 12'h168, 32'h0, 1'b0, 32'h0);
    access(1'b1, 1'b0, 12'h170, 32'h0, 1'b0, 32'h0);
    access(1'b0, 1'b1, 12'h170, 32'h12345678, 1'b0, 32'h0);
    $display("test unmapped done");
    for (int i = 0; i < 8; i++) begin
      settings.enable = i[0];
      settings.channel_id = i[2:0];
      settings.scheme_choice_field = i[1] ? 3'h4 : 3'h0;
      settings.negotiation_pending = i[2];
      access(1'b1, 1'b0, 12'h16C, 32'h0, 1'b1, 32'h077F0011);
    end
    $display("test settings independence done");
    // A request held through its answer is refused once, then nothing more is shown
    req.rd = 1'b1;
    req.addr = 12'h16C;
    @(negedge clock);
    check({31'h0, rsp.ack}, 32'h1);
    check(rsp.rdata, 32'h077F0011);
    @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    req.rd = 1'b0;
    @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    $display("test held request done");
    // Frozen clock enable holds the request untaken
    clk_en = 1'b0;
    req.rd = 1'b1;
    req.addr = 12'h16C;
    repeat (2) @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    clk_en = 1'b1;
    access(1'b1, 1'b0, 12'h16C, 32'h0, 1'b1, 32'h077F0011);
    // An answer frozen by clock enable keeps standing
    req.rd = 1'b1;
    @(negedge clock);
    clk_en = 1'b0;
    req.rd = 1'b0;
    @(negedge clock);
    check({31'h0, rsp.ack}, 32'h1);
    check(rsp.rdata, 32'h077F0011);
    clk_en = 1'b1;
    @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    $display("test clock enable done");
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    check({31'h0, rsp.ack}, 32'h0);
    rst_n = 1'b1;
    @(negedge clock);
    access(1'b1, 1'b0, 12'h16C, 32'h0, 1'b1, 32'h077F0011);
    $display("test second reset done");
    close_out();
  end
endmodule : tb_second_channel_arb_capability
`default_nettype wire

// [hw/cap_word_builder.sv]
// Packs the hardwired capability fields into one register word
`timescale 1ns/10ps
`default_nettype none
module cap_word_builder #(
  parameter logic [7:0] TABLE_OFFSET = cap_pkg::TABLE_OFFSET_VALUE,
  parameter logic [6:0] MAX_SLOTS = cap_pkg::MAX_SLOTS_VALUE,
  parameter logic [7:0] SCHEME_SUPPORT = cap_pkg::SCHEME_SUPPORT_VALUE
) (
  output logic [31:0] cap_word
);
  function automatic logic [31:0] pack_word(input logic [7:0] offs, input logic [6:0] slots,
                                            input logic [7:0] schemes);
    logic [31:0] w;
    w = 32'h00000000;
    w[cap_pkg::TABLE_OFFSET_MSB:cap_pkg::TABLE_OFFSET_LSB] = offs;
    w[cap_pkg::RSVD_HIGH_BIT] = 1'h0;
    w[cap_pkg::MAX_SLOTS_MSB:cap_pkg::MAX_SLOTS_LSB] = slots;
    w[cap_pkg::SNOOP_REJECT_BIT] = cap_pkg::SNOOP_REJECT_VALUE;
    w[cap_pkg::SWITCHING_ONLY_BIT] = cap_pkg::SWITCHING_ONLY_VALUE;
    w[cap_pkg::RSVD_MID_MSB:cap_pkg::RSVD_MID_LSB] = 6'h00;
    // Reserved scheme positions never advertise anything
    w[cap_pkg::SCHEME_MSB:cap_pkg::SCHEME_LSB] = schemes & 8'h3F;
    return w;
  endfunction : pack_word

  assign cap_word = pack_word(TABLE_OFFSET, MAX_SLOTS, SCHEME_SUPPORT);
endmodule : cap_word_builder
`default_nettype wire

// [hw/second_channel_arb_capability.sv]
// Read-only capability register of the second virtual channel in configuration space
`timescale 1ns/10ps
`default_nettype none
module second_channel_arb_capability (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire cap_pkg::cfg_req_t cfg_req,
  input wire cap_pkg::channel_settings_t channel_settings,
  output cap_pkg::cfg_rsp_t cfg_rsp
);
  function automatic logic addr_hit(input logic [11:0] addr);
    return addr[11:2] == cap_pkg::CAP_OFFSET[11:2];
  endfunction : addr_hit

  logic [31:0] cap_word;
  cap_pkg::access_state_t state_reg;
  cap_pkg::access_state_t state_next;
  cap_pkg::cfg_rsp_t rsp_reg;
  cap_pkg::cfg_rsp_t rsp_next;
  logic accept;

  cap_word_builder #(
    .TABLE_OFFSET(cap_pkg::TABLE_OFFSET_VALUE),
    .MAX_SLOTS(cap_pkg::MAX_SLOTS_VALUE),
    .SCHEME_SUPPORT(cap_pkg::SCHEME_SUPPORT_VALUE)
  ) u_builder (
    .cap_word(cap_word)
  );

  // One access is taken in idle; the answer follows in the next enabled cycle
  assign accept = (state_reg == cap_pkg::ST_IDLE) && (cfg_req.rd || cfg_req.wr);

  always_comb begin
    state_next = state_reg;
    rsp_next = rsp_reg;
    rsp_next.ack = 1'b0;
    case (state_reg)
      cap_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = cap_pkg::ST_ANSWER;
          rsp_next.ack = 1'b1;
          rsp_next.hit = addr_hit(cfg_req.addr);
          // Writes are acknowledged but never stored; reads see the fixed word
          if (cfg_req.rd && addr_hit(cfg_req.addr)) begin
            rsp_next.rdata = cap_word;
          end else begin
            rsp_next.rdata = 32'h00000000;
          end
        end
      end
      cap_pkg::ST_ANSWER: begin
        state_next = cap_pkg::ST_IDLE;
        rsp_next.hit = 1'b0;
        rsp_next.rdata = 32'h00000000;
      end
      default: begin
        state_next = cap_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= cap_pkg::ST_IDLE;
      rsp_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      rsp_reg <= rsp_next;
    end
  end

  assign cfg_rsp = rsp_reg;

  // Helper state for checks only: the last read answer and the settings it was given under
  logic seen_read_reg;
  logic seen_read_next;
  logic [31:0] last_read_reg;
  logic [31:0] last_read_next;
  cap_pkg::channel_settings_t last_settings_reg;
  cap_pkg::channel_settings_t last_settings_next;
  logic read_answer;
  assign read_answer = cfg_rsp.ack && cfg_rsp.hit && (cfg_rsp.rdata != 32'h00000000);

  always_comb begin
    seen_read_next = seen_read_reg;
    last_read_next = last_read_reg;
    last_settings_next = last_settings_reg;
    // Write answers carry zero and must not become the reference word
    if (read_answer) begin
      seen_read_next = 1'b1;
      last_read_next = cfg_rsp.rdata;
      last_settings_next = channel_settings;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seen_read_reg <= 1'b0;
      last_read_reg <= 32'h00000000;
      last_settings_reg <= '0;
    end else if (clk_en) begin
      seen_read_reg <= seen_read_next;
      last_read_reg <= last_read_next;
      last_settings_reg <= last_settings_next;
    end
  end

  logic read_hit_taken;
  logic write_hit_taken;
  assign read_hit_taken = clk_en && accept && cfg_req.rd && addr_hit(cfg_req.addr);
  assign write_hit_taken = clk_en && accept && cfg_req.wr && !cfg_req.rd && addr_hit(cfg_req.addr);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_read_taken;
    read_hit_taken;
  endsequence

  sequence s_answer_word;
    cfg_rsp.ack && cfg_rsp.hit && (cfg_rsp.rdata == cap_pkg::CAP_RESET);
  endsequence

  sequence s_write_taken;
    write_hit_taken;
  endsequence

  sequence s_write_answer;
    cfg_rsp.ack && cfg_rsp.hit && (cfg_rsp.rdata == 32'h00000000);
  endsequence

  a_read_full_word: assert property (s_read_taken |=> s_answer_word)
    else $error("Capability read did not return 077F0011h one cycle later");

  a_write_no_effect: assert property (s_write_taken |=> s_write_answer ##1 (cap_word == cap_pkg::CAP_RESET))
    else $error("Write to capability register was not ignored");

  a_table_offset: assert property (read_answer
      |-> cfg_rsp.rdata[cap_pkg::TABLE_OFFSET_MSB:cap_pkg::TABLE_OFFSET_LSB] == 8'h07)
    else $error("Table offset field is not 07h");

  a_max_slots: assert property (read_answer
      |-> cfg_rsp.rdata[cap_pkg::MAX_SLOTS_MSB:cap_pkg::MAX_SLOTS_LSB] == 7'h7F)
    else $error("Maximum slots field is not 7Fh");

  a_snoop_flag: assert property (read_answer |-> !cfg_rsp.rdata[cap_pkg::SNOOP_REJECT_BIT])
    else $error("Snoop rejection bit reads one");

  a_switching_flag: assert property (read_answer |-> !cfg_rsp.rdata[cap_pkg::SWITCHING_ONLY_BIT])
    else $error("Switching only bit reads one");

  a_reserved_zero: assert property (read_answer
      |-> !cfg_rsp.rdata[cap_pkg::RSVD_HIGH_BIT]
          && cfg_rsp.rdata[cap_pkg::RSVD_MID_MSB:cap_pkg::RSVD_MID_LSB] == 6'h00)
    else $error("Reserved capability bits are not zero");

  a_scheme_bits: assert property (read_answer
      |-> cfg_rsp.rdata[cap_pkg::SCHEME_FIXED_RR] && cfg_rsp.rdata[cap_pkg::SCHEME_TB_WRR128]
          && !cfg_rsp.rdata[cap_pkg::SCHEME_WRR32] && !cfg_rsp.rdata[cap_pkg::SCHEME_WRR64]
          && !cfg_rsp.rdata[cap_pkg::SCHEME_WRR128] && !cfg_rsp.rdata[cap_pkg::SCHEME_WRR256]
          && !cfg_rsp.rdata[cap_pkg::SCHEME_RSVD6] && !cfg_rsp.rdata[cap_pkg::SCHEME_RSVD7])
    else $error("Scheme support bits do not match fixed and time-based schemes");

  a_scheme_value: assert property (read_answer
      |-> cfg_rsp.rdata[cap_pkg::SCHEME_MSB:cap_pkg::SCHEME_LSB] == 8'h11)
    else $error("Scheme support field is not 11h");

  a_settings_ignored: assert property (read_answer && seen_read_reg && (channel_settings != last_settings_reg)
      |-> cfg_rsp.rdata == last_read_reg)
    else $error("Capability value changed with channel settings");

  a_single_ack: assert property (clk_en && cfg_rsp.ack |=> !cfg_rsp.ack)
    else $error("Answer lasted more than one enabled cycle");

  a_unmapped_zero: assert property (clk_en && accept && !addr_hit(cfg_req.addr)
      |=> cfg_rsp.ack && !cfg_rsp.hit && cfg_rsp.rdata == 32'h00000000)
    else $error("Unmapped access did not answer with zero and no hit");

  a_frozen_hold: assert property (!clk_en |=> $stable(state_reg) && $stable(cfg_rsp))
    else $error("State moved while clock enable was low");

  // A request that meets a showing answer is dropped; the master must hold it one more cycle
  sequence s_busy_request;
    clk_en && cfg_rsp.ack && (cfg_req.rd || cfg_req.wr);
  endsequence

  sequence s_back_to_idle;
    !cfg_rsp.ack && !cfg_rsp.hit && (cfg_rsp.rdata == 32'h00000000);
  endsequence

  a_busy_refused: assert property (s_busy_request |=> s_back_to_idle)
    else $error("Request was taken while an answer was showing");

  a_idle_quiet: assert property (!cfg_rsp.ack
      |-> !cfg_rsp.hit && cfg_rsp.rdata == 32'h00000000)
    else $error("Hit or data shown without an answer");

  a_reset_clears: assert property (@(posedge clock) disable iff (1'b0) !rst_n
      |=> !cfg_rsp.ack && !cfg_rsp.hit && cfg_rsp.rdata == 32'h00000000)
    else $error("Reset did not clear the answer");

  a_ack_follows: assert property (clk_en && accept |=> cfg_rsp.ack)
    else $error("Accepted request got no answer in the next cycle");

  a_hit_decode: assert property (clk_en && accept && addr_hit(cfg_req.addr)
      |=> cfg_rsp.ack && cfg_rsp.hit)
    else $error("Access to the capability word did not report a hit");

  a_pending_ignored: assert property (read_answer && channel_settings.negotiation_pending
      |-> cfg_rsp.rdata == cap_pkg::CAP_RESET)
    else $error("Capability value changed while negotiation pending");

  a_choice_ignored: assert property (read_answer && channel_settings.scheme_choice_field == 3'h4
      |-> cfg_rsp.rdata == cap_pkg::CAP_RESET)
    else $error("Capability value changed with the scheme choice");
endmodule : second_channel_arb_capability
`default_nettype wire

// [include/cap_pkg.sv]
// Constants and carriers for the second channel arbitration capability register
`default_nettype none
package cap_pkg;
  // Location in the extended configuration space
  localparam logic [11:0] CAP_OFFSET = 12'h16C;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;

  // Field positions
  localparam int TABLE_OFFSET_LSB = 24;
  localparam int TABLE_OFFSET_MSB = 31;
  localparam int RSVD_HIGH_BIT = 23;
  localparam int MAX_SLOTS_LSB = 16;
  localparam int MAX_SLOTS_MSB = 22;
  localparam int SNOOP_REJECT_BIT = 15;
  localparam int SWITCHING_ONLY_BIT = 14;
  localparam int RSVD_MID_LSB = 8;
  localparam int RSVD_MID_MSB = 13;
  localparam int SCHEME_LSB = 0;
  localparam int SCHEME_MSB = 7;

  // Scheme bit positions inside the support field
  localparam int SCHEME_FIXED_RR = 0;
  localparam int SCHEME_WRR32 = 1;
  localparam int SCHEME_WRR64 = 2;
  localparam int SCHEME_WRR128 = 3;
  localparam int SCHEME_TB_WRR128 = 4;
  localparam int SCHEME_WRR256 = 5;
  localparam int SCHEME_RSVD6 = 6;
  localparam int SCHEME_RSVD7 = 7;

  // Field values
  localparam logic [7:0] TABLE_OFFSET_VALUE = 8'h07;
  localparam logic [6:0] MAX_SLOTS_VALUE = 7'h7F;
  localparam logic SNOOP_REJECT_VALUE = 1'h0;
  localparam logic SWITCHING_ONLY_VALUE = 1'h0;
  localparam logic [7:0] SCHEME_SUPPORT_VALUE = 8'h11;
  localparam logic [31:0] CAP_RESET = 32'h077F0011;

  // Cycles from an accepted request to its answer
  localparam int ANSWER_CYCLES = 1;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic enable;
    logic [2:0] channel_id;
    logic [2:0] scheme_choice_field;
    logic negotiation_pending;
  } channel_settings_t;

  typedef enum logic {
    ST_IDLE,
    ST_ANSWER
  } access_state_t;
endpackage : cap_pkg
`default_nettype wire
